// [inc/pwm_ramp_pkg.sv]
// Constants and helpers for the fan PWM ramp and minimum-duty control block
package pwm_ramp_pkg;

	// ================================================================
	// Register map
	localparam logic [7:0] ACOUSTICS_ADDR  = 8'h62;
	localparam logic [7:0] ACOUSTICS_RESET = 8'h20;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;
	localparam logic [2:0] TACH_SYNC_RESET = 3'h6;

	// ================================================================
	// Field positions
	localparam int RATE_LSB      = 0;
	localparam int RATE_MSB      = 2;
	localparam int SMOOTH_BIT    = 3;
	localparam int SYNC_BIT      = 4;
	localparam int HOLD_PWM1_HOLD_MINIMUM_BIT = 5;
	localparam int HOLD_PWM2_HOLD_MINIMUM_BIT = 6;
	localparam int HOLD_PWM3_HOLD_MINIMUM_BIT = 7;

	// ================================================================
	// Timing: a slot is one duty step at the slowest rate
	localparam int  CLK_HZ        = 20000000;
	localparam int  SWEEP_TIME_MS = 37500;
	localparam int  DUTY_STEPS    = 255;
	localparam int  SLOT_CYCLES   = ((CLK_HZ / 1000) * SWEEP_TIME_MS) / DUTY_STEPS;
	localparam logic [7:0] DUTY_OFF = 8'h00;

	// ================================================================
	// Duty increment per time slot for each ramp-rate code
	function automatic logic [7:0] step_of(input logic [2:0] code);
		case (code)
			3'h0:    step_of = 8'h01;
			3'h1:    step_of = 8'h02;
			3'h2:    step_of = 8'h03;
			3'h3:    step_of = 8'h04;
			3'h4:    step_of = 8'h08;
			3'h5:    step_of = 8'h0c;
			3'h6:    step_of = 8'h18;
			default: step_of = 8'h30;
		endcase
	endfunction : step_of

endpackage : pwm_ramp_pkg

// [inc/ramp_if.sv]
// Control and result signals between the register logic and the duty slew limiter
`timescale 1ns/1ns
interface ramp_if;
	logic [7:0] target;
	logic [7:0] step;
	logic       enable;
	logic       tick;
	logic [7:0] duty;

	modport ctrl (output target, output step, output enable, output tick, input duty);
	modport slew (input target, input step, input enable, input tick, output duty);
endinterface : ramp_if

// [logic/duty_slew.sv]
// Slew limiter that walks the first PWM channel's duty toward its target
`timescale 1ns/1ns
module duty_slew (
	// Clock, reset, enable
	input  logic   clk,
	input  logic   rst_n,
	input  logic   ce,
	// Ramp control
	ramp_if.slew   rp
);

	logic [7:0] duty_q;
	logic [7:0] duty_d;
	logic [7:0] gap;

	assign rp.duty = duty_q;

	// ================================================================
	// Next duty: jump when smoothing is off, otherwise at most one step per slot
	always_comb
	begin
		gap    = (rp.target > duty_q) ? (rp.target - duty_q) : (duty_q - rp.target);
		duty_d = duty_q;
		if (!rp.enable)
			duty_d = rp.target;
		else if (rp.tick && (gap != 8'h00))
		begin
			if (rp.target > duty_q)
				duty_d = duty_q + ((gap < rp.step) ? gap : rp.step);
			else
				duty_d = duty_q - ((gap < rp.step) ? gap : rp.step);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			duty_q <= pwm_ramp_pkg::DUTY_OFF;
		else if (ce)
			duty_q <= duty_d;
	end

	// ================================================================
	// Checks
	a_slew_bounded: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && rp.enable) |=> (((duty_q > $past(duty_q)) ? (duty_q - $past(duty_q))
			: ($past(duty_q) - duty_q)) <= $past(rp.step)))
		else $error("duty moved more than one step");

	a_slew_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && rp.enable && !rp.tick) |=> $stable(duty_q))
		else $error("duty moved outside a slot");

	a_direct_jump: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !rp.enable) |=> (duty_q == $past(rp.target)))
		else $error("duty did not jump to target");

endmodule : duty_slew

// [logic/pwm_ramp_min_duty_control.sv]
// Acoustics control register with ramp, tach sync and below-threshold duty selection
`timescale 1ns/1ns
module pwm_ramp_min_duty_control #(
	parameter int SLOT_CYCLES = pwm_ramp_pkg::SLOT_CYCLES
) (
	// Clock, reset, enable
	input  logic       SYS_CLK,
	input  logic       RESETN,
	input  logic       CE,
	// Register port
	input  logic       REG_WE,
	input  logic       REG_RE,
	input  logic [7:0] REG_ADDR,
	input  logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Fan control inputs
	input  logic       AUTO_MODE,
	input  logic [2:0] BELOW_START,
	input  logic [7:0] DUTY1_CALC,
	input  logic [7:0] DUTY2_CALC,
	input  logic [7:0] DUTY3_CALC,
	input  logic [7:0] DUTY1_MIN,
	input  logic [7:0] DUTY2_MIN,
	input  logic [7:0] DUTY3_MIN,
	// Duty and tach sync outputs
	output logic [7:0] PWM1_DUTY,
	output logic [7:0] PWM2_DUTY,
	output logic [7:0] PWM3_DUTY,
	output logic [2:0] TACH_SYNC
);

	// ================================================================
	// Reset release
	logic       rst_s1_q;
	logic       rst_n;

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ================================================================
	// Acoustics register
	logic [7:0] ramp_ctrl_q;
	logic       reg_hit;
	logic [2:0] pwm1_ramp_rate;
	logic       pwm1_smooth_enable;
	logic       sync_three;
	logic       pwm1_hold_minimum;
	logic       pwm2_hold_minimum;
	logic       pwm3_hold_minimum;

	assign reg_hit            = (REG_ADDR == pwm_ramp_pkg::ACOUSTICS_ADDR);
	assign pwm1_ramp_rate     = ramp_ctrl_q[pwm_ramp_pkg::RATE_MSB:pwm_ramp_pkg::RATE_LSB];
	assign pwm1_smooth_enable = ramp_ctrl_q[pwm_ramp_pkg::SMOOTH_BIT];
	assign sync_three         = ramp_ctrl_q[pwm_ramp_pkg::SYNC_BIT];
	assign pwm1_hold_minimum  = ramp_ctrl_q[pwm_ramp_pkg::HOLD_PWM1_HOLD_MINIMUM_BIT];
	assign pwm2_hold_minimum  = ramp_ctrl_q[pwm_ramp_pkg::HOLD_PWM2_HOLD_MINIMUM_BIT];
	assign pwm3_hold_minimum  = ramp_ctrl_q[pwm_ramp_pkg::HOLD_PWM3_HOLD_MINIMUM_BIT];

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			ramp_ctrl_q <= pwm_ramp_pkg::ACOUSTICS_RESET;
		else if (CE && REG_WE && reg_hit)
			ramp_ctrl_q <= REG_WDATA;
	end

	// Reads are registered; any other address answers zero
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			REG_RDATA <= pwm_ramp_pkg::UNMAPPED_READ;
		else if (CE && REG_RE)
		begin
			if (reg_hit)
				REG_RDATA <= ramp_ctrl_q;
			else
				REG_RDATA <= pwm_ramp_pkg::UNMAPPED_READ;
		end
	end

	// ================================================================
	// Slot timer
	// The slowest code sweeps full scale in 37.5 s; faster codes
	// take bigger steps on the same slot so the timer is shared by all rates.
	logic [31:0] slot_cnt_q;
	logic        slot_tick;

	assign slot_tick = (slot_cnt_q == 32'(SLOT_CYCLES - 1));

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			slot_cnt_q <= 32'h0;
		else if (CE)
			slot_cnt_q <= slot_tick ? 32'h0 : slot_cnt_q + 32'h1;
	end

	// ================================================================
	// Below-threshold duty selection
	// Auto mode is an argument so the continuous assigns re-evaluate when it changes
	function automatic logic [7:0] pick_duty(
		input logic       auto_on,
		input logic       below,
		input logic       hold_min,
		input logic [7:0] calc,
		input logic [7:0] min_duty
	);
		if (auto_on && below)
			pick_duty = hold_min ? min_duty : pwm_ramp_pkg::DUTY_OFF;
		else
			pick_duty = calc;
	endfunction : pick_duty

	logic [7:0] target1;
	logic [7:0] target2;
	logic [7:0] target3;

	assign target1 = pick_duty(AUTO_MODE, BELOW_START[0], pwm1_hold_minimum,
		DUTY1_CALC, DUTY1_MIN);
	assign target2 = pick_duty(AUTO_MODE, BELOW_START[1], pwm2_hold_minimum,
		DUTY2_CALC, DUTY2_MIN);
	assign target3 = pick_duty(AUTO_MODE, BELOW_START[2], pwm3_hold_minimum,
		DUTY3_CALC, DUTY3_MIN);

	// ================================================================
	// First channel slew limiter
	ramp_if rp ();

	assign rp.target = target1;
	assign rp.step   = pwm_ramp_pkg::step_of(pwm1_ramp_rate);
	assign rp.enable = pwm1_smooth_enable;
	assign rp.tick   = slot_tick;

	duty_slew u_slew (
		.clk   (SYS_CLK),
		.rst_n (rst_n),
		.ce    (CE),
		.rp    (rp.slew)
	);

	assign PWM1_DUTY = rp.duty;

	// ================================================================
	// Channels two and three, tach synchronisation
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			PWM2_DUTY <= pwm_ramp_pkg::DUTY_OFF;
			PWM3_DUTY <= pwm_ramp_pkg::DUTY_OFF;
		end
		else if (CE)
		begin
			PWM2_DUTY <= target2;
			PWM3_DUTY <= target3;
		end
	end

	// Bit 0 is fan input 2, bit 1 input 3, bit 2 input 4
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			TACH_SYNC <= pwm_ramp_pkg::TACH_SYNC_RESET;
		else if (CE)
			TACH_SYNC <= {2'b11, sync_three};
	end

	// ================================================================
	// Checks
	a_reset_value: assert property (@(posedge SYS_CLK)
		$rose(rst_n) |-> (ramp_ctrl_q == 8'h20))
		else $error("register not at power-on value");

	a_write_lands: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && REG_WE && REG_ADDR == 8'h62) |=> (ramp_ctrl_q == $past(REG_WDATA)))
		else $error("write to acoustics register lost");

	a_read_back: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && REG_RE && !REG_WE && REG_ADDR == 8'h62) |=> (REG_RDATA == ramp_ctrl_q))
		else $error("readback differs from register");

	a_sync_all: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && sync_three) ##1 (CE && $stable(ramp_ctrl_q)) |-> (TACH_SYNC == 3'h7))
		else $error("fan input two not synchronised");

	a_sync_two: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && !sync_three) ##1 (CE && $stable(ramp_ctrl_q)) |-> (TACH_SYNC == 3'h6))
		else $error("fan input two wrongly synchronised");

	a_ch2_below: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && AUTO_MODE && BELOW_START[1])
		|=> (PWM2_DUTY == ($past(pwm2_hold_minimum) ? $past(DUTY2_MIN) : 8'h00)))
		else $error("channel two below-threshold duty wrong");

	a_ch3_below: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && AUTO_MODE && BELOW_START[2])
		|=> (PWM3_DUTY == ($past(pwm3_hold_minimum) ? $past(DUTY3_MIN) : 8'h00)))
		else $error("channel three below-threshold duty wrong");

	a_ch1_below: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && !pwm1_smooth_enable && AUTO_MODE && BELOW_START[0])
		|=> (PWM1_DUTY == ($past(pwm1_hold_minimum) ? $past(DUTY1_MIN) : 8'h00)))
		else $error("channel one below-threshold duty wrong");

	a_ch2_manual: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(CE && !AUTO_MODE) |=> (PWM2_DUTY == $past(DUTY2_CALC)))
		else $error("channel two ignored computed duty");

endmodule : pwm_ramp_min_duty_control

// [test/fan_model.sv]
// Behavioural fan that follows the duty it is given with some inertia
`timescale 1ns/1ns
module fan_model (
	// Clock and reset
	input  logic       clk,
	input  logic       rst_n,
	// Drive from the PWM channel
	input  logic [7:0] duty,
	output logic [7:0] speed_q
);
	// ================================================================
	// Rotor inertia
	// One speed unit per cycle, so an abrupt duty jump still spins up slowly.
	// The model only follows the duty; no rule binds the fan side.
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			speed_q <= 8'h00;
		else if (speed_q < duty)
			speed_q <= speed_q + 8'h01;
		else if (speed_q > duty)
			speed_q <= speed_q - 8'h01;
endmodule : fan_model

// [test/pwm_ramp_min_duty_control_tb.sv]
// Self-checking bench for the PWM ramp and minimum-duty control block
`timescale 1ns/1ns
`define CMP(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module pwm_ramp_min_duty_control_tb;
	localparam int SLOT = 8;
	localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
	logic       sys_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       we = 1'b0;
	logic       re = 1'b0;
	logic       ce = 1'b1;
	logic       auto_mode = 1'b0;
	logic [2:0] below = 3'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] calc [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] mins [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] rdata, pwm1, pwm2, pwm3, speed3;
	logic [2:0] tach;
	logic [10:0] exp_q [$];
	logic [10:0] item;
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         n;

	always #25 sys_clk = ~sys_clk;

	pwm_ramp_min_duty_control #(.SLOT_CYCLES(SLOT)) dut_u (
		.SYS_CLK(sys_clk), .RESETN(resetn), .CE(ce), .REG_WE(we), .REG_RE(re),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .AUTO_MODE(auto_mode),
		.BELOW_START(below), .DUTY1_CALC(calc[0]), .DUTY2_CALC(calc[1]),
		.DUTY3_CALC(calc[2]), .DUTY1_MIN(mins[0]), .DUTY2_MIN(mins[1]),
		.DUTY3_MIN(mins[2]), .PWM1_DUTY(pwm1), .PWM2_DUTY(pwm2), .PWM3_DUTY(pwm3),
		.TACH_SYNC(tach)
	);

	fan_model fan3_u (.clk(sys_clk), .rst_n(resetn), .duty(pwm3), .speed_q(speed3));

	task automatic finish_test();
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// Selector 0 read data, 1..3 channel duty, 4 tach sync, 5 fan speed
	task automatic expect_val(input logic [2:0] sel, input logic [7:0] val);
		exp_q.push_back({sel, val});
	endtask : expect_val

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge sys_clk);
		we = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		re = 1'b1;
		addr = a;
		@(negedge sys_clk);
		re = 1'b0;
		expect_val(3'h0, e);
	endtask : rd

	// ================================================================
	// Monitor: compares the oldest note with what the outputs show now
	initial
	forever
	begin
		wait (exp_q.size() > 0);
		item = exp_q.pop_front();
		case (item[10:8])
			3'h0:    `CMP("REG_RDATA", item[7:0], rdata)
			3'h1:    `CMP("PWM1_DUTY", item[7:0], pwm1)
			3'h2:    `CMP("PWM2_DUTY", item[7:0], pwm2)
			3'h3:    `CMP("PWM3_DUTY", item[7:0], pwm3)
			3'h4:    `CMP("TACH_SYNC", item[7:0], {5'h00, tach})
			default: `CMP("FAN3_SPEED", item[7:0], speed3)
		endcase
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	// ================================================================
	// Main sequence
	initial
	begin
		void'($urandom(49));
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (3) @(negedge sys_clk);
		expect_val(3'h4, 8'h06);
		rd(8'h62, 8'h20);
		rd(8'h13, 8'h00);
		wr(8'h13, 8'h5a);
		rd(8'h62, 8'h20);
		wr(8'h62, 8'h10);
		@(negedge sys_clk);
		expect_val(3'h4, 8'h07);
		n = $urandom;
		wr(8'h62, n[7:0]);
		rd(8'h62, n[7:0]);
		// A write while the clock enable is low must not land
		ce = 1'b0;
		wr(8'h62, ~n[7:0]);
		ce = 1'b1;
		rd(8'h62, n[7:0]);
		// Below-threshold choice per channel; the other channels track their computed duty
		for (int ch = 0; ch < 3; ch++)
			for (int hold = 0; hold < 2; hold++)
			begin
				wr(8'h62, hold ? (8'h20 << ch) : 8'h00);
				for (int k = 0; k < 3; k++)
				begin
					calc[k] = 8'($urandom);
					mins[k] = 8'($urandom);
				end
				auto_mode = 1'b1;
				below = 3'h1 << ch;
				@(negedge sys_clk);
				for (int k = 0; k < 3; k++)
					expect_val(3'(k + 1), (k != ch) ? calc[k] : (hold ? mins[k] : 8'h00));
			end
		// Outside automatic mode the hold bits have no effect
		auto_mode = 1'b0;
		below = 3'h7;
		@(negedge sys_clk);
		for (int k = 0; k < 3; k++)
			expect_val(3'(k + 1), calc[k]);
		// Slew limit: first step after a slot tick, then one more step a slot later
		for (int code = 0; code < 8; code++)
		begin
			wr(8'h62, 8'h00);
			calc[0] = 8'h00;
			@(negedge sys_clk);
			expect_val(3'h1, 8'h00);
			wr(8'h62, {5'h01, code[2:0]});
			calc[0] = 8'hff;
			n = 0;
			while (pwm1 === 8'h00 && n < 3 * SLOT)
			begin
				@(negedge sys_clk);
				n++;
			end
			expect_val(3'h1, STEPS[code]);
			repeat (SLOT) @(negedge sys_clk);
			expect_val(3'h1, STEPS[code] << 1);
		end
		wr(8'h62, 8'h00);
		@(negedge sys_clk);
		expect_val(3'h1, 8'hff);
		// The fan has had time to settle on the third channel's steady duty
		repeat (256) @(negedge sys_clk);
		expect_val(3'h5, calc[2]);
		@(negedge sys_clk);
		finish_test();
	end
endmodule : pwm_ramp_min_duty_control_tb
